//--- rtl/sts_top.sv
// Weekly schedule timer: APB register file and drive command outputs
module sts_top
  import sts_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire sts_apb_req_t apb_req,
  output sts_apb_rsp_t      apb_rsp,
  input  wire sts_time_t    now_time,
  input  wire logic [2:0]   now_weekday,
  output sts_drive_t        drive
);

  //////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    sts_time_t    s1_start;
    sts_time_t    s1_stop;
    logic [3:0]   s1_day;
    logic [1:0]   s1_action;
    logic [2:0]   s1_ref;
    sts_time_t    s2_start;
    sts_time_t    s2_stop;
    sts_apb_rsp_t rsp;
    sts_drive_t   drv;
    logic [1:0]   hits;
  } sts_state_t;

  sts_state_t st;
  sts_state_t next_st;

  //////////////////////////////////////////////////////////////////////////
  // Window evaluation

  sts_time_t  win_start [NUM_SCHED];
  sts_time_t  win_stop  [NUM_SCHED];
  logic [3:0] win_day   [NUM_SCHED];
  logic [1:0] win_hit;

  always_comb begin
    win_start[0] = st.s1_start;
    win_stop[0]  = st.s1_stop;
    win_day[0]   = st.s1_day;
    // Schedule two has no day code here; report its time window daily
    win_start[1] = st.s2_start;
    win_stop[1]  = st.s2_stop;
    win_day[1]   = DAY_DAILY;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SCHED; gi++) begin : g_win
      sts_window u_win (
        .weekday (now_weekday),
        .now     (now_time),
        .start   (win_start[gi]),
        .stop    (win_stop[gi]),
        .day_sel (win_day[gi]),
        .hit     (win_hit[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic [13:0] acc_idx;
  logic        acc_aligned;
  logic        acc_setup;
  logic        acc_commit;

  assign acc_idx     = apb_req.paddr[15:2];
  assign acc_aligned = (apb_req.paddr[1:0] == 2'h0);
  // First access cycle prepares the answer, second one completes it
  assign acc_setup   = apb_req.psel && apb_req.penable && !st.rsp.pready;
  assign acc_commit  = apb_req.psel && apb_req.penable && st.rsp.pready;

  function automatic logic [31:0] read_word(input sts_state_t s,
                                            input logic [13:0] idx,
                                            input sts_time_t t,
                                            input logic [2:0] wd);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      IDX_SCHED1_START:  w[15:0] = s.s1_start;
      IDX_SCHED1_STOP:   w[15:0] = s.s1_stop;
      IDX_SCHED1_DAY:    w[3:0]  = s.s1_day;
      IDX_SCHED1_ACTION: w[1:0]  = s.s1_action;
      IDX_SCHED1_REF:    w[2:0]  = s.s1_ref;
      IDX_SCHED2_START:  w[15:0] = s.s2_start;
      IDX_SCHED2_STOP:   w[15:0] = s.s2_stop;
      IDX_STATUS: begin
        w[ST_SCHED1_ACTIVE] = s.hits[0];
        w[ST_SCHED2_WINDOW] = s.hits[1];
        w[ST_RUN]           = s.drv.run;
        w[ST_LOOP_OFF]      = s.drv.loop_off;
      end
      IDX_NOW:           w[18:0] = {wd, t};
      default:           w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Mapped index, and for writes a legal value; anything else errs
  function automatic logic access_bad(input logic [13:0] idx,
                                      input logic wr,
                                      input logic [31:0] d);
    logic bad;
    bad = 1'b0;
    case (idx)
      IDX_SCHED1_START, IDX_SCHED1_STOP,
      IDX_SCHED2_START, IDX_SCHED2_STOP:
        bad = wr && ((d[31:16] != 16'h0000) || !sts_time_ok(d[15:0]));
      IDX_SCHED1_DAY:
        bad = wr && (d > {28'h0, DAY_MAX});
      IDX_SCHED1_ACTION:
        bad = wr && (d > {30'h0, ACT_RUN_NOPL});
      IDX_SCHED1_REF:
        bad = wr && (d > {29'h0, REF_MAX});
      IDX_STATUS, IDX_NOW:
        bad = wr;
      default:
        bad = 1'b1;
    endcase
    return bad;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;

    // Bus answer
    next_st.rsp.pready  = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    if (acc_setup) begin
      next_st.rsp.pready  = 1'b1;
      next_st.rsp.pslverr = !acc_aligned
                            || access_bad(acc_idx, apb_req.pwrite,
                                          apb_req.pwdata);
      next_st.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000
                            : read_word(st, acc_idx, now_time, now_weekday);
    end

    // Writes land only on the completing edge, and only when legal
    if (acc_commit && apb_req.pwrite && !st.rsp.pslverr) begin
      case (acc_idx)
        IDX_SCHED1_START:
          next_st.s1_start  = apb_req.pwdata[15:0];
        IDX_SCHED1_STOP:
          next_st.s1_stop   = apb_req.pwdata[15:0];
        IDX_SCHED1_DAY:
          next_st.s1_day    = apb_req.pwdata[3:0];
        IDX_SCHED1_ACTION:
          next_st.s1_action = apb_req.pwdata[1:0];
        IDX_SCHED1_REF:
          next_st.s1_ref    = apb_req.pwdata[2:0];
        IDX_SCHED2_START:
          next_st.s2_start  = apb_req.pwdata[15:0];
        IDX_SCHED2_STOP:
          next_st.s2_stop   = apb_req.pwdata[15:0];
        default: ;
      endcase
    end

    // Window results; an unreadable clock reading keeps everything idle
    next_st.hits = sts_time_ok(now_time) ? win_hit : 2'b00;

    // Drive command follows schedule one
    next_st.drv.dout      = next_st.hits[0];
    next_st.drv.run       = next_st.hits[0]
                            && (st.s1_action != ACT_DOUT_ONLY);
    next_st.drv.loop_off  = next_st.hits[0]
                            && (st.s1_action == ACT_RUN_NOPL);
    next_st.drv.ref_valid = next_st.drv.run;
    // Reference masked to preset one when not running, so idle is clean
    next_st.drv.ref_src   = next_st.drv.run ? st.s1_ref
                            : REF_PRESET_ONE;
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.s1_start       <= TIME_MIDNIGHT;
      st.s1_stop        <= TIME_MIDNIGHT;
      st.s1_day         <= DAY_OFF;
      st.s1_action      <= ACT_DOUT_ONLY;
      st.s1_ref         <= REF_PRESET_ONE;
      st.s2_start       <= TIME_MIDNIGHT;
      st.s2_stop        <= TIME_MIDNIGHT;
      st.rsp            <= '0;
      st.drv            <= '0;
      st.hits           <= 2'b00;
    end else begin
      st <= next_st;
    end
  end

  assign apb_rsp = st.rsp;
  assign drive   = st.drv;

endmodule

//--- inc/sts_pkg.sv
// Package: register map, field layouts and carriers of the schedule timer
package sts_pkg;

  // Printed offsets are register indices; byte address is four times it
  localparam logic [13:0] IDX_SCHED1_START  = 14'h3206;
  localparam logic [13:0] IDX_SCHED1_STOP   = 14'h3207;
  localparam logic [13:0] IDX_SCHED1_DAY    = 14'h3208;
  localparam logic [13:0] IDX_SCHED1_ACTION = 14'h3209;
  localparam logic [13:0] IDX_SCHED1_REF    = 14'h320a;
  localparam logic [13:0] IDX_SCHED2_START  = 14'h320b;
  localparam logic [13:0] IDX_SCHED2_STOP   = 14'h320c;
  localparam logic [13:0] IDX_STATUS        = 14'h3220;
  localparam logic [13:0] IDX_NOW           = 14'h3221;

  // Time of day: hours in [15:8], minutes in [7:0], 00:00 to 24:00
  localparam int          TIME_HOUR_LSB  = 8;
  localparam logic [7:0]  TIME_HOUR_MAX  = 8'h18;
  localparam logic [7:0]  TIME_MIN_LIMIT = 8'h3c;
  localparam logic [15:0] TIME_MIDNIGHT  = 16'h0000;
  localparam logic [15:0] TIME_END_OF_DAY = 16'h1800;

  // Day selection codes
  localparam logic [3:0] DAY_OFF      = 4'h0;
  localparam logic [3:0] DAY_DAILY    = 4'h1;
  localparam logic [3:0] DAY_WORKWEEK = 4'h2;
  localparam logic [3:0] DAY_WEEKEND  = 4'h3;
  localparam logic [3:0] DAY_MONDAY   = 4'h4;
  localparam logic [3:0] DAY_MAX      = 4'ha;
  // Weekday input: 0 Monday through 6 Sunday
  localparam logic [2:0] WD_SATURDAY  = 3'h5;
  localparam logic [2:0] WD_SUNDAY    = 3'h6;

  // Action selection codes
  localparam logic [1:0] ACT_DOUT_ONLY = 2'h0;
  localparam logic [1:0] ACT_RUN       = 2'h1;
  localparam logic [1:0] ACT_RUN_NOPL  = 2'h2;

  // Reference source codes: 0..3 presets, 4 terminals, 5 serial
  localparam logic [2:0] REF_PRESET_ONE = 3'h0;
  localparam logic [2:0] REF_MAX        = 3'h5;

  // Status register bit positions
  localparam int ST_SCHED1_ACTIVE = 0;
  localparam int ST_SCHED2_WINDOW = 1;
  localparam int ST_RUN           = 2;
  localparam int ST_LOOP_OFF      = 3;

  localparam int NUM_SCHED = 2;

  typedef logic [15:0] sts_time_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } sts_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sts_apb_rsp_t;

  typedef struct packed {
    logic       dout;
    logic       run;
    logic       loop_off;
    logic       ref_valid;
    logic [2:0] ref_src;
  } sts_drive_t;

  // Legal clock reading, 24:00 included
  function automatic logic sts_time_ok(input sts_time_t t);
    logic [7:0] hr;
    logic [7:0] mn;
    hr = t[15:TIME_HOUR_LSB];
    mn = t[TIME_HOUR_LSB-1:0];
    return ((hr < TIME_HOUR_MAX) && (mn < TIME_MIN_LIMIT))
           || (t == TIME_END_OF_DAY);
  endfunction

endpackage

//--- rtl/sts_window.sv
// Window match: day selection against weekday, time against start and stop
module sts_window
  import sts_pkg::*;
(
  input  wire logic [2:0] weekday,
  input  wire sts_time_t  now,
  input  wire sts_time_t  start,
  input  wire sts_time_t  stop,
  input  wire logic [3:0] day_sel,
  output logic            hit
);

  function automatic logic day_match(input logic [3:0] sel,
                                     input logic [2:0] wd);
    logic weekend;
    weekend = (wd == WD_SATURDAY) || (wd == WD_SUNDAY);
    case (sel)
      DAY_OFF:      return 1'b0;
      DAY_DAILY:    return 1'b1;
      DAY_WORKWEEK: return !weekend;
      DAY_WEEKEND:  return weekend;
      default:      return (sel - DAY_MONDAY) == {1'b0, wd};
    endcase
  endfunction

  // Packed hh:mm compares in order; start above stop never opens
  always_comb begin
    hit = day_match(day_sel, weekday)
          && (now >= start) && (now < stop);
  end

endmodule

//--- bench/sts_clock_src.sv
// Partner model: time-of-day and weekday source for the schedule timer
module sts_clock_src
  import sts_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire sts_time_t  set_time,
  input  wire logic [2:0] set_wd,
  output sts_time_t       now_time,
  output logic [2:0]      now_weekday
);
  // Registered, so a reading never moves between edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      now_time    <= TIME_MIDNIGHT;
      now_weekday <= 3'h0;
    end else begin
      now_time    <= set_time;
      now_weekday <= set_wd;
    end
  end
endmodule

//--- bench/sts_top_monitor.sv
// Checker: concurrent properties on the schedule timer ports
module sts_top_monitor
  import sts_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire sts_apb_req_t apb_req,
  input wire sts_apb_rsp_t apb_rsp,
  input wire sts_time_t    now_time,
  input wire logic [2:0]   now_weekday,
  input wire sts_drive_t   drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  a_run_has_dout: assert property (drive.run |-> drive.dout)
    else $error("run without output");
  a_loop_has_run: assert property (drive.loop_off |-> drive.run)
    else $error("loop off without run");
  a_ref_with_run: assert property (drive.ref_valid == drive.run)
    else $error("reference valid differs from run");
  a_ref_idle_zero: assert property (!drive.run |-> !drive.ref_src)
    else $error("reference while not running");
  a_ref_in_range: assert property (drive.ref_src <= REF_MAX)
    else $error("reference code out of range");
  a_bad_time_off: assert property
    (!sts_time_ok(now_time) |=> !drive.dout)
    else $error("active on illegal time");
  a_end_day_off: assert property
    (now_time == TIME_END_OF_DAY |=> !drive.dout)
    else $error("active at end of day");
  a_access_ready: assert property
    (apb_req.psel && apb_req.penable && !apb_rsp.pready |=> apb_rsp.pready)
    else $error("no answer one cycle into access");
endmodule

//--- bench/sts_top_test.sv
// Testbench: register access, refusals and schedule outputs
module sts_top_test
  import sts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  sts_apb_req_t req = '0;
  sts_apb_rsp_t rsp;
  sts_time_t    set_time = 16'h0000;
  sts_time_t    now_time;
  logic [2:0]   set_wd = 3'h0;
  logic [2:0]   now_weekday;
  sts_drive_t   drive;
  int           fail_count = 0;
  int           n_compared = 0;
  int           seed = 23120;
  logic [2:0]   rs;
  sts_time_t    tt;
  sts_drive_t   ed;
  // Edges of the 08:00 to 17:00 window, end of day and an illegal hour
  sts_time_t    tbl [6] = '{16'h073b, 16'h0800, 16'h103b, 16'h1100,
                            16'h1800, 16'h1a00};

  always #25 pclk = ~pclk;

  sts_clock_src src (.pclk(pclk), .presetn(presetn), .set_time(set_time),
    .set_wd(set_wd), .now_time(now_time), .now_weekday(now_weekday));
  sts_top dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .now_time(now_time), .now_weekday(now_weekday),
    .drive(drive));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  // One APB transfer; pready and the answer taken at the rising edge
  task automatic acc(input logic w, input logic [13:0] ix,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic eerr);
    int n;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {ix, 2'b00},
             pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      fail_count++;
      give_verdict;
    end
    chk("pslverr", {31'h0, eerr}, {31'h0, rsp.pslverr});
    if (!w && !eerr)
      chk("prdata", exp, rsp.prdata);
    req <= '0;
    @(posedge pclk);
  endtask

  function automatic sts_drive_t exp_drv(logic [3:0] day, logic [1:0] act,
      logic [2:0] rs, logic [2:0] wd, sts_time_t t);
    logic       hit;
    sts_drive_t r;
    hit = day == 1 || (day == 2 && wd < 5) || (day == 3 && wd > 4)
          || (day > 3 && wd == day - 4);
    hit = hit && t >= 16'h0800 && t < 16'h1100;
    r = '0;
    r.dout = hit;
    r.run = hit && act != 0;
    r.loop_off = hit && act == 2;
    r.ref_valid = r.run;
    r.ref_src = r.run ? rs : 3'h0;
    return r;
  endfunction

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++)
      acc(0, IDX_SCHED1_START + 14'(i), 0, 0, 0);
    $display("test reset values done");
    acc(1, IDX_SCHED1_DAY, 32'hb, 0, 1);
    acc(1, IDX_SCHED1_ACTION, 32'h3, 0, 1);
    acc(1, IDX_SCHED1_REF, 32'h6, 0, 1);
    acc(1, IDX_SCHED1_START, 32'h1801, 0, 1);
    acc(0, 14'h3210, 0, 0, 1);
    acc(0, IDX_SCHED1_DAY, 0, 0, 0);
    acc(1, IDX_SCHED2_START, 32'h1800, 0, 0);
    acc(0, IDX_SCHED2_START, 0, 32'h1800, 0);
    acc(1, IDX_SCHED2_STOP, 32'h1800, 0, 0);
    $display("test refusals done");
    acc(1, IDX_SCHED1_START, 32'h0800, 0, 0);
    acc(1, IDX_SCHED1_STOP, 32'h1100, 0, 0);
    acc(0, IDX_SCHED1_STOP, 0, 32'h1100, 0);
    for (int d = 0; d < 11; d++)
      for (int a = 0; a < 3; a++) begin
        rs = 3'($unsigned($random(seed)) % 6);
        acc(1, IDX_SCHED1_DAY, 32'(d), 0, 0);
        acc(1, IDX_SCHED1_ACTION, 32'(a), 0, 0);
        acc(1, IDX_SCHED1_REF, {29'h0, rs}, 0, 0);
        tt = tbl[$unsigned($random(seed)) % 6];
        set_time <= tt;
        set_wd <= 3'($unsigned($random(seed)) % 7);
        repeat (4) @(posedge pclk);
        chk("drive", {25'h0, exp_drv(4'(d), 2'(a), rs, set_wd, tt)},
            {25'h0, drive});
        ed = exp_drv(4'(d), 2'(a), rs, set_wd, tt);
        acc(0, IDX_STATUS, 0, {28'h0, ed.loop_off, ed.run, 1'b0, ed.dout},
            0);
        acc(0, IDX_NOW, 0, {13'h0, set_wd, tt}, 0);
      end
    $display("test schedule outputs done");
    give_verdict;
  end
endmodule

bind sts_top sts_top_monitor mon (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .now_time(now_time),
  .now_weekday(now_weekday), .drive(drive));
